// file: hdl/crx_rx_timing.sv
// receive timing window checker with apb registers and interrupt
// assumes cec_in idles high, sample_clock near 32.768 kHz, both pins
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - start rise must fall inside rise window
// - start cycle length must lie inside limits
// - start cycle max is 154 plus field
// - start cycle min is 141 minus field
// - start rise latest is 128 plus field
// - start rise earliest is 115 minus field
// - zero bit latest rise 56 plus field
// - zero bit earliest rise 43 minus field
// - one bit latest rise 26 plus field
// - waveform errors only when check enabled
// - rise between one and zero windows errs
// - one bit earliest rise 13 minus field
module crx_rx_timing
  import crx_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cec_in,
  input  wire logic        sample_clock,
  output logic             irq,
  output var  logic        start_valid
);

  // synchronised pins
  logic [1:0] pins_sync;
  logic       line_level;
  logic       sample_level;
  logic       line_prev;
  logic       fall;
  logic       rise;

  crx_sync #(
    .W (2)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({sample_clock, cec_in}),
    .sync_out (pins_sync)
  );

  assign line_level   = pins_sync[0];
  assign sample_level = pins_sync[1];
  assign fall         = line_prev && !line_level;
  assign rise         = !line_prev && line_level;

  // period counter
  logic             cnt_clr;
  logic [CNT_W-1:0] cnt;

  crx_tick_counter u_cnt (
    .pclk         (pclk),
    .presetn      (presetn),
    .sample_level (sample_level),
    .clr          (cnt_clr),
    .count        (cnt)
  );

  // registers
  logic        rx_en;
  logic [31:0] rx_start_bit_timing;
  logic [31:0] rx_waveform_error_timing;
  logic [3:0]  evt_status;
  logic [3:0]  evt_mask;
  logic        next_rx_en;
  logic [31:0] next_start_timing;
  logic [31:0] next_wave_timing;
  logic [3:0]  next_evt_status;
  logic [3:0]  next_evt_mask;
  logic [31:0] next_prdata;
  logic        wr_access;
  logic        rd_setup;
  logic        addr_ok;

  // thresholds
  logic [7:0] start_cycle_max;
  logic [7:0] start_cycle_min;
  logic [7:0] start_rise_max;
  logic [7:0] start_rise_min;
  logic [7:0] zero_rise_latest;
  logic [7:0] zero_rise_earliest;
  logic [7:0] one_rise_latest;
  logic [7:0] one_rise_earliest;
  logic       waveform_check_enable;

  function automatic logic [7:0] fld(input logic [31:0] r, input int unsigned pos);
    fld = {5'h00, r[pos+:3]};
  endfunction : fld

  always_comb begin
    start_cycle_max    = BASE_START_CYCLE_MAX
                         + fld(rx_start_bit_timing, POS_START_CYCLE_MAX);
    start_cycle_min    = BASE_START_CYCLE_MIN
                         - fld(rx_start_bit_timing, POS_START_CYCLE_MIN);
    start_rise_max     = BASE_START_RISE_MAX
                         + fld(rx_start_bit_timing, POS_START_RISE_MAX);
    start_rise_min     = BASE_START_RISE_MIN
                         - fld(rx_start_bit_timing, POS_START_RISE_MIN);
    zero_rise_latest   = BASE_ZERO_RISE_LATEST
                         + fld(rx_waveform_error_timing, POS_ZERO_RISE_LATEST);
    zero_rise_earliest = BASE_ZERO_RISE_EARLY
                         - fld(rx_waveform_error_timing, POS_ZERO_RISE_EARLIEST);
    one_rise_latest    = BASE_ONE_RISE_LATEST
                         + fld(rx_waveform_error_timing, POS_ONE_RISE_LATEST);
    one_rise_earliest  = BASE_ONE_RISE_EARLY
                         - fld(rx_waveform_error_timing, POS_ONE_RISE_EARLIEST);
    waveform_check_enable = rx_waveform_error_timing[POS_WAVE_EN];
  end

  // receive state machine
  crx_state_e state;
  crx_state_e next_state;
  logic [3:0] evt_set;
  logic       next_start_valid;
  logic       rise_in_start_win;
  logic       cycle_in_start_win;
  logic       rise_bad_shape;

  always_comb begin
    rise_in_start_win  = (cnt >= start_rise_min) && (cnt <= start_rise_max);
    cycle_in_start_win = (cnt >= start_cycle_min) && (cnt <= start_cycle_max);
    rise_bad_shape     = (cnt < one_rise_earliest)
                         || ((cnt > one_rise_latest) && (cnt < zero_rise_earliest))
                         || (cnt > zero_rise_latest);
  end

  always_comb begin
    next_state       = state;
    evt_set          = '0;
    cnt_clr          = 1'b0;
    next_start_valid = 1'b0;
    if (!rx_en) begin
      next_state = CRX_IDLE;
    end else begin
      case (state)
        CRX_IDLE: begin
          if (fall) begin
            cnt_clr    = 1'b1;
            next_state = CRX_START_LOW;
          end
        end
        CRX_START_LOW: begin
          if (rise) begin
            if (rise_in_start_win) begin
              next_state = CRX_START_HIGH;
            end else begin
              evt_set[EVT_START_ERR] = 1'b1;
              next_state             = CRX_IDLE;
            end
          end else if (cnt > start_rise_max) begin
            evt_set[EVT_START_ERR] = 1'b1;
            next_state             = CRX_IDLE;
          end
        end
        CRX_START_HIGH: begin
          cnt_clr = fall;
          if (fall) begin
            if (cycle_in_start_win) begin
              evt_set[EVT_START_OK] = 1'b1;
              next_start_valid      = 1'b1;
              next_state            = CRX_DATA_LOW;
            end else begin
              evt_set[EVT_START_ERR] = 1'b1;
              next_state             = CRX_START_LOW;
            end
          end else if (cnt > start_cycle_max) begin
            evt_set[EVT_START_ERR] = 1'b1;
            next_state             = CRX_IDLE;
          end
        end
        CRX_DATA_LOW: begin
          if (rise) begin
            evt_set[EVT_DATA_BIT] = 1'b1;
            evt_set[EVT_WAVE_ERR] = waveform_check_enable && rise_bad_shape;
            next_state            = CRX_DATA_HIGH;
          end else if (cnt > zero_rise_latest) begin
            evt_set[EVT_WAVE_ERR] = waveform_check_enable;
            next_state            = CRX_IDLE;
          end
        end
        CRX_DATA_HIGH: begin
          cnt_clr = fall;
          if (fall) begin
            next_state = CRX_DATA_LOW;
          end else if (cnt > start_cycle_max) begin
            next_state = CRX_IDLE;
          end
        end
        default: begin
          next_state = CRX_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= CRX_IDLE;
      line_prev   <= 1'b1;
      start_valid <= 1'b0;
    end else begin
      state       <= next_state;
      line_prev   <= line_level;
      start_valid <= next_start_valid;
    end
  end

  // apb slave
  assign pready    = 1'b1;
  assign wr_access = psel && penable && pwrite;
  assign rd_setup  = psel && !penable && !pwrite;

  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_START, OFS_WAVE, OFS_STATUS, OFS_MASK, OFS_STATE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pslverr = psel && penable && !addr_ok;

  always_comb begin
    next_rx_en        = rx_en;
    next_start_timing = rx_start_bit_timing;
    next_wave_timing  = rx_waveform_error_timing;
    next_evt_mask     = evt_mask;
    next_evt_status   = evt_status;
    next_prdata       = prdata;
    if (wr_access) begin
      case (paddr)
        OFS_CTRL:   next_rx_en        = pwdata[POS_RX_EN];
        OFS_START:  next_start_timing = pwdata & MASK_START;
        OFS_WAVE:   next_wave_timing  = pwdata & MASK_WAVE;
        OFS_STATUS: next_evt_status   = evt_status & ~pwdata[3:0];
        OFS_MASK:   next_evt_mask     = pwdata[3:0];
        default:    next_rx_en        = rx_en;
      endcase
    end
    next_evt_status = next_evt_status | evt_set;
    if (rd_setup) begin
      case (paddr)
        OFS_CTRL:   next_prdata = {31'h0, rx_en};
        OFS_START:  next_prdata = rx_start_bit_timing;
        OFS_WAVE:   next_prdata = rx_waveform_error_timing;
        OFS_STATUS: next_prdata = {28'h0, evt_status};
        OFS_MASK:   next_prdata = {28'h0, evt_mask};
        OFS_STATE:  next_prdata = {21'h0, state, cnt};
        default:    next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_en                    <= RST_CTRL;
      rx_start_bit_timing      <= RST_START;
      rx_waveform_error_timing <= RST_WAVE;
      evt_status               <= RST_EVT;
      evt_mask                 <= RST_EVT;
      prdata                   <= 32'h0000_0000;
    end else begin
      rx_en                    <= next_rx_en;
      rx_start_bit_timing      <= next_start_timing;
      rx_waveform_error_timing <= next_wave_timing;
      evt_status               <= next_evt_status;
      evt_mask                 <= next_evt_mask;
      prdata                   <= next_prdata;
    end
  end

  assign irq = |(evt_status & evt_mask);

endmodule : crx_rx_timing
`default_nettype wire

// file: hdl/crx_pkg.sv
// constants for the receive timing window checker
// assumes a 100 MHz pclk and a slow sample clock arriving on a pin
package crx_pkg;

  localparam int unsigned CNT_W = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_START  = 8'h04;
  localparam logic [7:0] OFS_WAVE   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_STATE  = 8'h14;

  // reset values
  localparam logic [31:0] RST_START = 32'h0000_0000;
  localparam logic [31:0] RST_WAVE  = 32'h0000_0000;
  localparam logic        RST_CTRL  = 1'b0;
  localparam logic [3:0]  RST_EVT   = 4'h0;

  // start timing field positions
  localparam int unsigned POS_START_CYCLE_MAX = 12;
  localparam int unsigned POS_START_CYCLE_MIN = 8;
  localparam int unsigned POS_START_RISE_MAX  = 4;
  localparam int unsigned POS_START_RISE_MIN  = 0;
  // waveform timing field positions
  localparam int unsigned POS_ZERO_RISE_LATEST   = 20;
  localparam int unsigned POS_ZERO_RISE_EARLIEST = 16;
  localparam int unsigned POS_ONE_RISE_LATEST    = 12;
  localparam int unsigned POS_ONE_RISE_EARLIEST  = 8;
  localparam int unsigned POS_WAVE_EN            = 0;
  localparam int unsigned POS_RX_EN              = 0;

  // writable bits of the timing registers
  localparam logic [31:0] MASK_START = 32'h0000_7777;
  localparam logic [31:0] MASK_WAVE  = 32'h0077_7701;

  // base times in sample clock periods
  localparam logic [7:0] BASE_START_CYCLE_MAX   = 8'd154;
  localparam logic [7:0] BASE_START_CYCLE_MIN   = 8'd141;
  localparam logic [7:0] BASE_START_RISE_MAX    = 8'd128;
  localparam logic [7:0] BASE_START_RISE_MIN    = 8'd115;
  localparam logic [7:0] BASE_ZERO_RISE_LATEST  = 8'd56;
  localparam logic [7:0] BASE_ZERO_RISE_EARLY   = 8'd43;
  localparam logic [7:0] BASE_ONE_RISE_LATEST   = 8'd26;
  localparam logic [7:0] BASE_ONE_RISE_EARLY    = 8'd13;

  // status bit positions
  localparam int unsigned EVT_START_OK  = 0;
  localparam int unsigned EVT_START_ERR = 1;
  localparam int unsigned EVT_WAVE_ERR  = 2;
  localparam int unsigned EVT_DATA_BIT  = 3;

  typedef enum logic [2:0] {
    CRX_IDLE       = 3'b000,
    CRX_START_LOW  = 3'b001,
    CRX_START_HIGH = 3'b010,
    CRX_DATA_LOW   = 3'b011,
    CRX_DATA_HIGH  = 3'b100
  } crx_state_e;

endpackage : crx_pkg

// file: hdl/crx_sync.sv
// two flip-flop synchroniser, one per bit
// assumes asynchronous inputs from pins
`timescale 1ns/1ns
`default_nettype none
module crx_sync #(
  parameter int unsigned W = 2
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          meta[i]     <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta[i]     <= async_in[i];
          sync_out[i] <= meta[i];
        end
      end
    end
  endgenerate
endmodule : crx_sync
`default_nettype wire

// file: hdl/crx_tick_counter.sv
// counts sample clock periods since the last clear, saturating
// assumes a synchronised sample clock level on pclk
`timescale 1ns/1ns
`default_nettype none
module crx_tick_counter
  import crx_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             sample_level,
  input  wire logic             clr,
  output var  logic [CNT_W-1:0] count
);
  logic             sample_prev;
  logic             tick;
  logic [CNT_W-1:0] next_count;

  assign tick = sample_level && !sample_prev;

  always_comb begin
    next_count = count;
    if (clr) begin
      next_count = '0;
    end else if (tick && (count != {CNT_W{1'b1}})) begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_prev <= 1'b1;
      count       <= '0;
    end else begin
      sample_prev <= sample_level;
      count       <= next_count;
    end
  end
endmodule : crx_tick_counter
`default_nettype wire

// file: bench/crx_rx_timing_props.sv
// assertions on the ports of crx_rx_timing
// assumes bind onto crx_rx_timing, pin levels on cec_in and sample_clock
`timescale 1ns/1ns
`default_nettype none
module crx_rx_timing_props
  import crx_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        cec_in,
  input wire logic        sample_clock,
  input wire logic        irq,
  input wire logic        start_valid
);
  logic [31:0] st_q;
  logic        en_q;
  logic [7:0]  cnt;
  logic [7:0]  rise_c;
  logic [7:0]  cyc_c;
  logic        acc;
  assign acc = psel & penable;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // mirror of start timing and enable, pin-level tick counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
      en_q <= 1'b0;
      cnt <= '0;
      rise_c <= '0;
      cyc_c <= '0;
    end else begin
      if (acc && pwrite && paddr == OFS_START) st_q <= pwdata;
      if (acc && pwrite && paddr == OFS_CTRL) en_q <= pwdata[0];
      if ($fell(cec_in)) begin
        cnt <= '0;
        cyc_c <= cnt;
      end else if ($rose(sample_clock) && cnt != 8'hff) begin
        cnt <= cnt + 8'h01;
      end
      if ($rose(cec_in)) rise_c <= cnt;
    end
  end
  ready_in_access_a: assert property (acc |-> pready)
    else $error("pready low in access");
  slverr_map_a: assert property (
    acc && paddr[1:0] == 2'b00 |-> pslverr == (paddr > OFS_STATE))
    else $error("pslverr wrong");
  start_read_a: assert property (
    acc && !pwrite && paddr == OFS_START |-> prdata == (st_q & MASK_START))
    else $error("start timing readback wrong");
  wave_rsv_a: assert property (
    acc && !pwrite && paddr == OFS_WAVE |-> (prdata & ~MASK_WAVE) == 32'h0)
    else $error("reserved wave bits not zero");
  valid_pulse_a: assert property (start_valid |=> !start_valid)
    else $error("start_valid longer than one cycle");
  valid_fall_a: assert property (start_valid |-> !cec_in && $past(cec_in, 8))
    else $error("start_valid not after a fall");
  valid_en_a: assert property (start_valid |-> en_q)
    else $error("start_valid with reception off");
  cycle_win_a: assert property (start_valid |->
    cyc_c >= BASE_START_CYCLE_MIN - st_q[10:8] && cyc_c <= BASE_START_CYCLE_MAX + st_q[14:12])
    else $error("start cycle out of window");
  rise_win_a: assert property (start_valid |->
    rise_c >= BASE_START_RISE_MIN - st_q[2:0] && rise_c <= BASE_START_RISE_MAX + st_q[6:4])
    else $error("start rise out of window");
  cover property (start_valid);
  cover property (acc && pslverr);
  cover property ($fell(irq));
endmodule : crx_rx_timing_props
bind crx_rx_timing crx_rx_timing_props i_props (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .cec_in, .sample_clock, .irq, .start_valid
);
`default_nettype wire

// file: bench/crx_bus_node.sv
// far bus node driving the line, plus a shortened sample clock
// assumes pclk at 100 MHz; line has a pull-up, so idle is high
`timescale 1ns/1ns
`default_nettype none
module crx_bus_node (
  input  wire logic pclk,
  output var  logic cec_in,
  output var  logic sample_clock
);
  logic [2:0] ph;
  initial begin
    ph = '0;
    cec_in = 1'b1;
    sample_clock = 1'b0;
  end
  // sample clock of 8 pclk periods
  always @(posedge pclk) begin
    ph <= ph + 3'd1;
    sample_clock <= ph[2];
  end
  // low for rise ticks, high until cyc ticks; edges on sample clock falls
  task automatic bit_cell(input int rise, input int cyc);
    @(negedge sample_clock);
    cec_in <= 1'b0;
    repeat (rise) @(posedge sample_clock);
    @(negedge sample_clock);
    cec_in <= 1'b1;
    repeat (cyc - rise) @(posedge sample_clock);
  endtask : bit_cell
endmodule : crx_bus_node
`default_nettype wire

// file: bench/crx_rx_timing_tb.sv
// self-checking bench for crx_rx_timing
// assumes crx_bus_node on the line and the bound checker
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) \
  begin \
    checks_done++; \
    if ((a) !== (e)) begin \
      mismatches++; \
      $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); \
    end \
  end
module crx_rx_timing_tb
  import crx_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic        irq, start_valid, cec_in, sample_clock, sv_seen, ok, bad;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, f;
  int          mismatches, checks_done, seed, rmin, rmax, cmin, cmax, oe, ol, ze, zl;
  int          lim [8];
  crx_rx_timing i_crx_rx_timing (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .cec_in, .sample_clock, .irq, .start_valid);
  crx_bus_node i_crx_bus_node (.pclk, .cec_in, .sample_clock);
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (start_valid === 1'b1) sv_seen <= 1'b1;
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // reception off and confirmed off before timing fields move
  task automatic set_timing(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CTRL, 32'h0);
    `CHK(rd[0], 1'b0)
    apb(1'b1, a, d);
    apb(1'b1, OFS_CTRL, 32'h1);
  endtask : set_timing
  // start bit, one data bit, then idle long enough to drop the frame
  task automatic frame(input int r, input int c, input int dr);
    sv_seen = 1'b0;
    i_crx_bus_node.bit_cell(r, c);
    i_crx_bus_node.bit_cell(dr, dr + 24);
    repeat (180) @(posedge sample_clock);
    @(posedge pclk);
  endtask : frame
  task automatic status_is(input logic [2:0] e, input logic ei);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK(rd[2:0], e)
    `CHK(irq, ei)
    apb(1'b1, OFS_STATUS, 32'hf);
    `CHK(irq, 1'b0)
  endtask : status_is
  function automatic logic wave_bad(input int r, oe, ol, ze, zl);
    return r < oe || (r > ol && r < ze) || r > zl;
  endfunction : wave_bad
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  initial begin
    #1000000;
    mismatches++;
    results();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, sv_seen} = '0;
    seed = 86870;
    mismatches = 0;
    checks_done = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_START, 32'h0);
    `CHK(rd, RST_START)
    apb(1'b0, OFS_WAVE, 32'h0);
    `CHK(rd, RST_WAVE)
    apb(1'b1, OFS_START, 32'hffff_ffff);
    apb(1'b0, OFS_START, 32'h0);
    `CHK(rd, MASK_START)
    apb(1'b1, OFS_WAVE, 32'hffff_ffff);
    apb(1'b0, OFS_WAVE, 32'h0);
    `CHK(rd, MASK_WAVE)
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, {1'b1, 32'h0})
    set_timing(OFS_WAVE, 32'h0);
    apb(1'b1, OFS_MASK, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      f = $random(seed);
      set_timing(OFS_START, f);
      rmin = 115 - f[2:0];
      rmax = 128 + f[6:4];
      cmin = 141 - f[10:8];
      cmax = 154 + f[14:12];
      case (i)
        0: frame(rmin, cmin, 20);
        1: frame(rmin - 1, cmin, 20);
        2: frame(rmax, cmax, 20);
        3: frame(rmax + 1, cmax, 20);
        4: frame(rmax, cmin - 1, 20);
        default: frame(rmin, cmax + 1, 20);
      endcase
      ok = (i == 0 || i == 2);
      `CHK(sv_seen, ok)
      status_is({1'b0, !ok, ok}, ok);
    end
    $display("test start windows done");
    apb(1'b1, OFS_MASK, 32'h4);
    for (int i = 0; i < 8; i++) begin
      f = $random(seed);
      f[0] = (i % 4 != 3);
      set_timing(OFS_WAVE, f);
      oe = 13 - f[10:8];
      ol = 26 + f[14:12];
      ze = 43 - f[18:16];
      zl = 56 + f[22:20];
      lim = '{oe - 1, oe, ol, ol + 1, ze - 1, ze, zl, zl + 1};
      frame(rmin, cmin, lim[i]);
      bad = f[0] & wave_bad(lim[i], oe, ol, ze, zl);
      status_is({bad, 2'b01}, bad);
    end
    $display("test waveform windows done");
    results();
  end
endmodule : crx_rx_timing_tb
`default_nettype wire
